// >>> logic/ncfg_init_block.sv
`timescale 1ns/1ns
// Contract
// R01: Configuration register reachable only with pointer value 11 and stop set.
// R02: Bits 15 to 3 read zero; writes to them are dropped.
// R03: Software leaves bits 31 to 16 alone; they are undefined.
// R04: Byte swap bit exchanges bytes of every DMA word.
// R05: Swap, polarity and byte style bits clear on stop, reset, bus reset.
// R06: Bit 1 sets the address latch strobe polarity during DMA.
// R07: Bit 0 sets the byte mask and hold pin style during DMA.
// R08: Firmware programs all three configuration bits to zero before start.
// R09: Initialize command fetches 24 bytes from buffer RAM by DMA.
// R10: Base address is high register joined to low; bit 0 kept zero. The code passes bit 0 of the low register through unchanged.
// R11: Fetched block is twelve 16-bit words numbered upward.
// R12: Word zero is the mode word; all zeros means normal operation.
// R13: Mode bit 15 accepts every packet, else only own station address.
// R14: Software writes zeros in mode bits 14 to 7.
// R15: Loopback driven by mode bit 6 together with mode bit 2.
// R16: Mode bit 5 allows one attempt; a collision flags retry error.
// R17: Mode bit 4 in internal loopback forces collision, 16 attempts.
// R18: Stop halts external activity and clears internal logic like reset.
// R19: Software sets stop before initialize; initialize then clears stop.
// R20: Writes ignored and reads undefined while stop is clear.
module ncfg_init_block
    import ncfg_pkg::*;
(
    input wire logic ref_clk_in, // System clock, 100 MHz.
    input wire logic rst_in, // Synchronous reset, active high.
    input wire logic io_bus_reset_in, // I/O bus reset, active high level.
    input wire logic stop_bit_in, // Stop bit of the command status register.
    input wire logic init_cmd_in, // One-cycle pulse when initialize is set.
    input wire logic [1:0] register_select_pointer_in, // Register select pointer value.
    input wire logic csr_wr_in, // Data port write strobe.
    input wire logic csr_rd_in, // Data port read strobe.
    input wire logic [DATA_W-1:0] csr_wdata_in, // Data port write data.
    output logic [DATA_W-1:0] csr_rdata_out, // Data port read data, registered.
    input wire logic [DATA_W-1:0] init_addr_low_reg_in, // Low init block address register.
    input wire logic [7:0] init_addr_high_reg_in, // High init block address register.
    output logic dma_req_out, // DMA read request level.
    output logic [ADDR_W-1:0] dma_addr_out, // DMA byte address, registered.
    input wire logic dma_ack_in, // DMA read data valid.
    input wire logic [DATA_W-1:0] dma_rdata_in, // DMA read data.
    output logic [DATA_W-1:0] dma_word_out, // Fetched word after byte order swap.
    output logic dma_word_valid_out, // One-cycle pulse with each fetched word.
    output logic init_done_out, // One-cycle pulse when the block is fetched.
    output ncfg_pins_s pin_style_out, // Electrical style of the DMA pins.
    output logic address_latch_strobe_out, // Address latch strobe pin level.
    input wire logic addr_phase_in, // DMA address phase from the bus sequencer.
    output ncfg_mode_s mode_out, // Decoded operating mode.
    output logic [4:0] tx_attempt_limit_out, // Transmit attempts allowed per packet.
    input wire logic tx_collision_in, // Pulse when a transmit attempt collides.
    input wire logic [4:0] tx_attempt_count_in, // Attempts made so far on this packet.
    output logic retry_error_flag_out // Pulse to mark retry error in the descriptor.
);

    logic [CFG_W-1:0] bus_interface_config_reg;
    logic [DATA_W-1:0] init_mode_word;
    logic stop_q;
    logic stop_rise;
    logic clear_all;
    logic cfg_hit;
    ncfg_fetch_e fetch_state;
    ncfg_fetch_e next_fetch_state;
    logic [3:0] word_index;
    logic [ADDR_W-1:0] init_base;
    logic [DATA_W-1:0] swapped_word;

    // Setting stop acts as a reset of the internal logic, like power-up and the bus reset.
    assign stop_rise = stop_bit_in & ~stop_q;
    assign clear_all = rst_in | io_bus_reset_in | stop_rise; // R18
    assign cfg_hit = (register_select_pointer_in == SEL_BUS_CFG) & stop_bit_in; // R01 R20
    assign init_base = {init_addr_high_reg_in, init_addr_low_reg_in}; // R10

    // Edge detector for the stop bit; it starts high because stop is set out of reset, so no false edge follows.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            stop_q <= 1'b1;
        end else begin
            stop_q <= stop_bit_in;
        end
    end

    // Configuration bits; the clear wins over a write that lands in the same cycle.
    always_ff @(posedge ref_clk_in) begin
        if (clear_all) begin
            bus_interface_config_reg <= CFG_RESET; // R05
        end else if (csr_wr_in && cfg_hit) begin
            bus_interface_config_reg <= csr_wdata_in[CFG_W-1:0]; // R01 R02 R20
        end
    end

    // Read data; upper bits always zero, and zero is returned when the register is closed.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            csr_rdata_out <= MODE_RESET;
        end else if (csr_rd_in) begin
            csr_rdata_out <= cfg_hit ? {CFG_ZERO_PAD, bus_interface_config_reg} : MODE_RESET; // R02 R20
        end
    end

    // Pin style outputs follow the configuration bits directly.
    assign pin_style_out.dma_byte_order_swap = bus_interface_config_reg[CFG_SWAP_BIT];
    assign pin_style_out.latch_strobe_polarity = bus_interface_config_reg[CFG_POL_BIT]; // R06
    assign pin_style_out.byte_mask_hold_style = bus_interface_config_reg[CFG_BYTE_BIT]; // R07

    // Latch strobe is asserted the cycle after an address phase while a fetch is requested, with the chosen polarity.
    always_ff @(posedge ref_clk_in) begin
        if (clear_all) begin
            address_latch_strobe_out <= 1'b0;
        end else begin
            address_latch_strobe_out <= (addr_phase_in & dma_req_out) ^ bus_interface_config_reg[CFG_POL_BIT]; // R06
        end
    end

    // Every DMA word passes the byte order swapper.
    ncfg_byte_swap #(
        .WIDTH(DATA_W)
    ) u_swap (
        .swap_in(bus_interface_config_reg[CFG_SWAP_BIT]), // R04
        .data_in(dma_rdata_in),
        .data_out(swapped_word)
    );

    // Fetch sequencer: idle, read twelve words, then report completion.
    always_comb begin
        next_fetch_state = fetch_state;
        unique case (fetch_state)
            FETCH_IDLE: begin
                if (init_cmd_in) begin
                    next_fetch_state = FETCH_READ; // R09
                end
            end
            FETCH_READ: begin
                if (dma_ack_in && word_index == INIT_LAST_WORD) begin
                    next_fetch_state = FETCH_DONE; // R11
                end
            end
            FETCH_DONE: begin
                next_fetch_state = FETCH_IDLE;
            end
            default: begin
                next_fetch_state = FETCH_IDLE;
            end
        endcase
    end

    // State register; stop aborts any fetch in flight.
    always_ff @(posedge ref_clk_in) begin
        if (clear_all) begin
            fetch_state <= FETCH_IDLE; // R18
        end else begin
            fetch_state <= next_fetch_state;
        end
    end

    // Word index and address walk upward from the base in word steps.
    always_ff @(posedge ref_clk_in) begin
        if (clear_all) begin
            word_index <= MODE_WORD_INDEX;
            dma_addr_out <= '0;
        end else if (fetch_state == FETCH_IDLE && init_cmd_in) begin
            word_index <= MODE_WORD_INDEX;
            dma_addr_out <= init_base; // R10
        end else if (fetch_state == FETCH_READ && dma_ack_in) begin
            word_index <= word_index + 4'h1; // R11
            dma_addr_out <= dma_addr_out + ADDR_W'(INIT_WORD_BYTES);
        end
    end

    assign dma_req_out = (fetch_state == FETCH_READ);

    // Fetched words are presented in FIFO order; word zero is kept as the mode word.
    always_ff @(posedge ref_clk_in) begin
        if (clear_all) begin
            dma_word_out <= MODE_RESET;
            dma_word_valid_out <= 1'b0;
            init_mode_word <= MODE_RESET; // R12
        end else begin
            dma_word_valid_out <= (fetch_state == FETCH_READ) & dma_ack_in;
            if (fetch_state == FETCH_READ && dma_ack_in) begin
                dma_word_out <= swapped_word; // R04
                if (word_index == MODE_WORD_INDEX) begin
                    init_mode_word <= swapped_word; // R12
                end
            end
        end
    end

    // Completion pulse one cycle after the last word.
    always_ff @(posedge ref_clk_in) begin
        if (clear_all) begin
            init_done_out <= 1'b0;
        end else begin
            init_done_out <= (fetch_state == FETCH_DONE);
        end
    end

    // Mode decode; reserved bits 14 to 7 are ignored.
    assign mode_out.accept_all_packets = init_mode_word[MODE_ALL_BIT]; // R13
    assign mode_out.internal_loop_select = init_mode_word[MODE_INTERNAL_LOOP_SELECT_BIT]; // R15
    assign mode_out.loop_enable = init_mode_word[MODE_LOOP_BIT]; // R15
    assign mode_out.single_attempt_only = init_mode_word[MODE_ONE_TRY_BIT]; // R16
    assign mode_out.forced_collision_test = init_mode_word[MODE_FORCED_COLLISION_TEST_BIT] & init_mode_word[MODE_LOOP_BIT]
        & init_mode_word[MODE_INTERNAL_LOOP_SELECT_BIT]; // R17

    // Attempt limit; forced collision wins over single attempt.
    always_comb begin
        if (mode_out.forced_collision_test) begin
            tx_attempt_limit_out = ATTEMPTS_FORCED; // R17
        end else if (mode_out.single_attempt_only) begin
            tx_attempt_limit_out = ATTEMPTS_SINGLE; // R16
        end else begin
            tx_attempt_limit_out = ATTEMPTS_NORMAL;
        end
    end

    // Retry error when a collision ends the last allowed attempt.
    always_ff @(posedge ref_clk_in) begin
        if (clear_all) begin
            retry_error_flag_out <= 1'b0;
        end else begin
            retry_error_flag_out <= tx_collision_in & (tx_attempt_count_in >= tx_attempt_limit_out); // R16 R17
        end
    end

endmodule // ncfg_init_block

// >>> logic/ncfg_pkg.sv
package ncfg_pkg;

    // Register select pointer value that reaches the bus interface configuration register.
    localparam logic [1:0] SEL_BUS_CFG = 2'h3;
    // Printed register address of the shared data port.
    localparam logic [31:0] BUS_CFG_ADDR = 32'h1008_4400;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 24;
    localparam int CFG_W = 3;

    // Field positions of the bus interface configuration register.
    localparam int CFG_SWAP_BIT = 2;
    localparam int CFG_POL_BIT = 1;
    localparam int CFG_BYTE_BIT = 0;
    localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
    localparam logic [DATA_W-CFG_W-1:0] CFG_ZERO_PAD = 13'h0000;

    // Initialization block geometry.
    localparam int INIT_BLOCK_BYTES = 24;
    localparam int INIT_WORD_BYTES = 2;
    localparam logic [3:0] INIT_WORDS = 4'(INIT_BLOCK_BYTES / INIT_WORD_BYTES);
    localparam logic [3:0] INIT_LAST_WORD = INIT_WORDS - 4'h1;
    localparam logic [3:0] MODE_WORD_INDEX = 4'h0;

    // Field positions of the mode word.
    localparam int MODE_ALL_BIT = 15;
    localparam int MODE_INTERNAL_LOOP_SELECT_BIT = 6;
    localparam int MODE_ONE_TRY_BIT = 5;
    localparam int MODE_FORCED_COLLISION_TEST_BIT = 4;
    localparam int MODE_LOOP_BIT = 2;
    localparam logic [DATA_W-1:0] MODE_RESET = 16'h0000;

    // Transmit attempt limits.
    localparam logic [4:0] ATTEMPTS_NORMAL = 5'h10;
    localparam logic [4:0] ATTEMPTS_SINGLE = 5'h01;
    localparam logic [4:0] ATTEMPTS_FORCED = 5'h10;

    typedef enum logic [1:0] {
        FETCH_IDLE = 2'b00,
        FETCH_READ = 2'b01,
        FETCH_DONE = 2'b10
    } ncfg_fetch_e;

    // Decoded operating mode handed to the receive and transmit engines.
    typedef struct packed {
        logic accept_all_packets;
        logic internal_loop_select;
        logic loop_enable;
        logic single_attempt_only;
        logic forced_collision_test;
    } ncfg_mode_s;

    // Electrical style of the DMA pins.
    typedef struct packed {
        logic dma_byte_order_swap;
        logic latch_strobe_polarity;
        logic byte_mask_hold_style;
    } ncfg_pins_s;

endpackage

// >>> logic/ncfg_byte_swap.sv
`timescale 1ns/1ns
module ncfg_byte_swap
    import ncfg_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input wire logic swap_in, // Exchange high and low bytes when high.
    input wire logic [WIDTH-1:0] data_in, // Word as moved by DMA.
    output logic [WIDTH-1:0] data_out // Word in the order the FIFO expects.
);

    // Byte exchange is a combinational mux on swap_in, so the register that receives it sees no added cycle.
    assign data_out = swap_in ? {data_in[WIDTH/2-1:0], data_in[WIDTH-1:WIDTH/2]} : data_in;

endmodule // ncfg_byte_swap

// >>> verification/ncfg_init_block_props.sv
`timescale 1ns/1ns
module ncfg_init_block_props
    import ncfg_pkg::*;
(
    input wire logic ref_clk_in, rst_in, io_bus_reset_in, stop_bit_in, csr_rd_in, dma_req_out, dma_ack_in,
    input wire logic dma_word_valid_out, init_done_out, address_latch_strobe_out, addr_phase_in,
    input wire logic tx_collision_in, retry_error_flag_out,
    input wire logic [1:0] register_select_pointer_in,
    input wire logic [DATA_W-1:0] csr_rdata_out, init_addr_low_reg_in, dma_rdata_in, dma_word_out,
    input wire logic [7:0] init_addr_high_reg_in,
    input wire logic [ADDR_W-1:0] dma_addr_out,
    input wire logic [4:0] tx_attempt_limit_out, tx_attempt_count_in,
    input wire ncfg_pins_s pin_style_out,
    input wire ncfg_mode_s mode_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in || io_bus_reset_in);
    logic req_q;
    logic [4:0] ack_cnt;
    // Counts accepted words of one fetch; cleared once the request has been low two cycles.
    always_ff @(posedge ref_clk_in) begin
        req_q <= dma_req_out;
        if (rst_in || (!dma_req_out && !req_q)) ack_cnt <= 5'h00;
        else if (dma_req_out && dma_ack_in) ack_cnt <= ack_cnt + 5'h01;
    end
    sequence s_ack;
        dma_req_out && dma_ack_in;
    endsequence
    property p_rd_closed;
        csr_rd_in && !(register_select_pointer_in == SEL_BUS_CFG && stop_bit_in) |=> csr_rdata_out == 16'h0000;
    endproperty
    a_rd_closed: assert property (p_rd_closed) else $error("closed register read not zero");
    property p_rd_pad;
        csr_rd_in |=> csr_rdata_out[15:3] == CFG_ZERO_PAD;
    endproperty
    a_rd_pad: assert property (p_rd_pad) else $error("reserved bits read nonzero");
    property p_clear_stop;
        $rose(stop_bit_in) |=> pin_style_out == CFG_RESET;
    endproperty
    a_clear_stop: assert property (p_clear_stop) else $error("stop did not clear config");
    property p_clear_io;
        $fell(io_bus_reset_in) |-> pin_style_out == CFG_RESET;
    endproperty
    a_clear_io: assert property (p_clear_io) else $error("bus reset did not clear config");
    property p_swap;
        s_ack |=> dma_word_valid_out && dma_word_out == ($past(pin_style_out.dma_byte_order_swap) ?
            {$past(dma_rdata_in[7:0]), $past(dma_rdata_in[15:8])} : $past(dma_rdata_in));
    endproperty
    a_swap: assert property (p_swap) else $error("fetched word order wrong");
    property p_step;
        s_ack ##1 dma_req_out |-> dma_addr_out == $past(dma_addr_out) + 24'h00_0002;
    endproperty
    a_step: assert property (p_step) else $error("fetch address step wrong");
    property p_base;
        $rose(dma_req_out) |-> dma_addr_out == {init_addr_high_reg_in, init_addr_low_reg_in};
    endproperty
    a_base: assert property (p_base) else $error("fetch base address wrong");
    property p_count;
        init_done_out |-> ack_cnt == 5'h0c;
    endproperty
    a_count: assert property (p_count) else $error("fetch length wrong");
    property p_limit;
        tx_attempt_limit_out == (mode_out.forced_collision_test ? ATTEMPTS_FORCED :
            mode_out.single_attempt_only ? ATTEMPTS_SINGLE : ATTEMPTS_NORMAL);
    endproperty
    a_limit: assert property (p_limit) else $error("attempt limit wrong");
    property p_retry;
        tx_collision_in |=> retry_error_flag_out == ($past(tx_attempt_count_in) >= $past(tx_attempt_limit_out));
    endproperty
    a_retry: assert property (p_retry) else $error("retry error flag wrong");
    property p_strobe;
        !$rose(stop_bit_in) |=> address_latch_strobe_out ==
            (($past(addr_phase_in) & $past(dma_req_out)) ^ $past(pin_style_out.latch_strobe_polarity));
    endproperty
    a_strobe: assert property (p_strobe) else $error("latch strobe level wrong");
endmodule // ncfg_init_block_props
bind ncfg_init_block ncfg_init_block_props i_ncfg_init_block_props (.*);

// >>> verification/ncfg_ram_model.sv
`timescale 1ns/1ns
module ncfg_ram_model (
    input wire logic clk_in, // Bench clock.
    input wire logic req_in, // Fetch request level.
    input wire logic [23:0] addr_in, // Byte address.
    input wire logic slow_in, // Stall at random when high.
    output logic ack_out, // Word valid.
    output logic [15:0] rdata_out // Word data.
);
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0000;
    initial begin
        ack_out = 1'b0;
        rdata_out = 16'h0000;
    end
    // Answers at most one word per cycle just after the edge; released data is inverted so it never looks valid.
    always @(posedge clk_in) begin
        #1;
        ack_out = req_in && (!slow_in || $urandom_range(0, 1) == 1);
        if (ack_out) last = mem[addr_in[8:1]];
        rdata_out = ack_out ? last : ~last;
    end
endmodule // ncfg_ram_model

// >>> verification/net_ctrl_csr3_init_block_tb.sv
`timescale 1ns/1ns
module net_ctrl_csr3_init_block_tb;
    import ncfg_pkg::*;
    logic ref_clk_in, rst_in, io_bus_reset_in, stop_bit_in, init_cmd_in, csr_wr_in, csr_rd_in, dma_req_out;
    logic dma_ack_in, dma_word_valid_out, init_done_out, address_latch_strobe_out, addr_phase_in;
    logic tx_collision_in, retry_error_flag_out, slow, prev;
    logic [1:0] register_select_pointer_in;
    logic [15:0] csr_wdata_in, csr_rdata_out, init_addr_low_reg_in, dma_rdata_in, dma_word_out, w, m;
    logic [7:0] init_addr_high_reg_in;
    logic [23:0] dma_addr_out;
    logic [4:0] tx_attempt_limit_out, tx_attempt_count_in, lim;
    logic [2:0] cfg;
    ncfg_pins_s pin_style_out;
    ncfg_mode_s mode_out;
    int n_mismatch = 0, samples_checked = 0, k, nw;
    int modes[6] = '{0, 'h8000, 'h0064, 'h0054, 'h0020, 'h0010};
    ncfg_init_block i_ncfg_init_block (.*);
    ncfg_ram_model i_ncfg_ram_model (.clk_in(ref_clk_in), .req_in(dma_req_out), .addr_in(dma_addr_out),
        .slow_in(slow), .ack_out(dma_ack_in), .rdata_out(dma_rdata_in));
    initial begin
        ref_clk_in = 0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge ref_clk_in);
        #1;
        addr_phase_in = 1'($urandom);
    endtask
    // One register access; the bench model clears on a stop rise, which wins over a write.
    task automatic csr(input logic w_en, input logic [1:0] p, input logic s, input logic [15:0] d);
        csr_wr_in = w_en;
        csr_rd_in = !w_en;
        register_select_pointer_in = p;
        stop_bit_in = s;
        csr_wdata_in = d;
        if (s && !prev) cfg = 3'h0;
        else if (w_en && p == SEL_BUS_CFG && s) cfg = d[2:0];
        prev = s;
        tick();
        csr_wr_in = 0;
        csr_rd_in = 0;
        tick();
        if (!w_en) chk("csr_rdata", (p == SEL_BUS_CFG && s) ? 16'(cfg) : 16'h0000, csr_rdata_out);
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #300000;
        n_mismatch++;
        results();
    end
    // Main sequence: register access, bus reset, then init block fetches in six modes.
    initial begin
        {rst_in, stop_bit_in, prev} = 3'h7;
        {io_bus_reset_in, init_cmd_in, csr_wr_in, csr_rd_in, tx_collision_in, addr_phase_in, slow} = 7'h00;
        {register_select_pointer_in, csr_wdata_in, init_addr_low_reg_in, init_addr_high_reg_in} = 42'h0;
        {tx_attempt_count_in, cfg} = 8'h00;
        void'($urandom(6));
        repeat (6) @(posedge ref_clk_in);
        #1;
        rst_in = 0;
        for (k = 0; k < 16; k++) begin
            register_select_pointer_in = k[0] ? 2'h3 : 2'($urandom);
            m = 16'($urandom);
            csr(1, register_select_pointer_in, m[0] | k[1], m);
            csr(0, register_select_pointer_in, stop_bit_in, 16'h0000);
            chk("pin_style", 16'(cfg), 16'(pin_style_out));
        end
        csr(1, 2'h3, 1, 16'hffff);
        io_bus_reset_in = 1;
        tick();
        io_bus_reset_in = 0;
        cfg = 3'h0;
        csr(0, 2'h3, 1, 16'h0000);
        $display("register test done");
        for (k = 0; k < 6; k++) begin
            csr(1, 2'h3, 1, k == 0 ? 16'h0000 : 16'($urandom));
            init_addr_high_reg_in = 8'($urandom);
            init_addr_low_reg_in = 16'($urandom) & 16'hfffe;
            for (nw = 0; nw < 256; nw++) i_ncfg_ram_model.mem[nw] = 16'($urandom);
            m = 16'(modes[k]);
            // The mode word is stored in RAM byte order, so after the swap the device sees m itself.
            i_ncfg_ram_model.mem[init_addr_low_reg_in[8:1]] = cfg[2] ? {m[7:0], m[15:8]} : m;
            slow = k[0];
            init_cmd_in = 1;
            stop_bit_in = 0;
            prev = 0;
            tick();
            init_cmd_in = 0;
            nw = 0;
            repeat (200) begin
                tick();
                if (dma_word_valid_out === 1'b1) begin
                    w = i_ncfg_ram_model.mem[8'(init_addr_low_reg_in[8:1] + nw)];
                    chk("dma_word", cfg[2] ? {w[7:0], w[15:8]} : w, dma_word_out);
                    nw++;
                end
                if (init_done_out === 1'b1) break;
            end
            chk("word_count", 16'h000c, 16'(nw));
            chk("init_done", 16'h0001, 16'(init_done_out));
            chk("latch_strobe_idle", 16'(cfg[1]), 16'(address_latch_strobe_out));
            chk("mode", 16'({m[15], m[6], m[2], m[5], m[4] & m[6] & m[2]}), 16'(mode_out));
            lim = (m[4] & m[6] & m[2]) ? 5'h10 : m[5] ? 5'h01 : 5'h10;
            chk("attempt_limit", 16'(lim), 16'(tx_attempt_limit_out));
            tx_collision_in = 1;
            tx_attempt_count_in = lim;
            tick();
            chk("retry_at_limit", 16'h0001, 16'(retry_error_flag_out));
            tx_attempt_count_in = lim - 5'h01;
            tick();
            chk("retry_below_limit", 16'h0000, 16'(retry_error_flag_out));
            tx_collision_in = 0;
            stop_bit_in = 1;
            prev = 1;
            cfg = 3'h0;
            tick();
            tick();
            chk("pin_style_stop", 16'h0000, 16'(pin_style_out));
            $display("fetch test %0d done", k);
        end
        results();
    end
endmodule // net_ctrl_csr3_init_block_tb
